// ==== common/armw_pkg.sv ====
// Purpose: Shared constants and types for the attribute read/modify/write command unit
// Assumes: One system clock at 10 MHz, byte-wide command and reply channels
// Notes:   Opcodes double as attribute selectors; reply codes are arbitrary choices

package armw_pkg;

	// Attribute opcodes
	localparam logic [7:0] OPC_SYMBOL     = 8'h20;
	localparam logic [7:0] OPC_BITPORT    = 8'h21;
	localparam logic [7:0] OPC_VOLUME     = 8'h23;
	localparam logic [7:0] OPC_BRIGHTNESS = 8'h24;
	localparam logic [7:0] OPC_WATCHDOG   = 8'h25;
	localparam logic [7:0] OPC_UNLOCK     = 8'h26;
	localparam logic [7:0] OPC_KEY_DELAY  = 8'h28;
	localparam logic [7:0] OPC_KEY_RATE   = 8'h29;
	localparam logic [7:0] OPC_TIME_ZONE  = 8'h2A;
	localparam logic [7:0] OPC_LED_RATIO  = 8'h2B;
	localparam logic [7:0] OPC_DIAG       = 8'h2E;
	localparam logic [7:0] OPC_CONTRAST   = 8'h2F;

	// Reply codes, values arbitrary
	localparam logic [7:0] REPLY_ACK = 8'hFA;
	localparam logic [7:0] REPLY_NAK = 8'hFE;

	// Unlock code for the factory area, ASCII w
	localparam logic [7:0] UNLOCK_CODE = 8'h77;

	// Field positions
	localparam int SYMBOL_LAMPS_W      = 9;
	localparam int BIT_PANEL_POWER     = 1;
	localparam int BIT_SYNC_INVERT_A   = 2;
	localparam int BIT_SYNC_INVERT_B   = 3;
	localparam int BIT_BOOT_ROM_DIS    = 4;
	localparam int BIT_CSYNC_ENABLE    = 5;
	localparam int DIAG_BIT_CMD_SHOW   = 0;
	localparam int DIAG_BIT_KBD_9600   = 1;

	// Reset values
	localparam logic [15:0] RST_SYMBOL   = 16'h0000;
	localparam logic [7:0]  RST_BITPORT  = 8'h02;
	localparam logic [7:0]  RST_WATCHDOG = 8'h00;
	localparam logic [7:0]  RST_BYTE     = 8'h00;

	// Nonvolatile save selectors
	localparam logic [1:0] NV_SEL_VOLUME     = 2'h0;
	localparam logic [1:0] NV_SEL_BRIGHTNESS = 2'h1;
	localparam logic [1:0] NV_SEL_TIME_ZONE  = 2'h2;

	// Timing: watchdog unit is one second
	localparam int CLK_FREQ_HZ    = 10_000_000;
	localparam int WD_UNIT_S      = 1;
	localparam int WD_TICK_CYCLES = CLK_FREQ_HZ * WD_UNIT_S;

	// Command sequencer states
	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_MASK,
		ST_VALUE,
		ST_EXEC,
		ST_REPLY
	} armw_state_t;

endpackage : armw_pkg

// ==== verilog/armw_wdog.sv ====
// Purpose: Host watchdog timer counting whole seconds up to a programmed period
// Assumes: Kick and period come from logic on the same clock
// Notes:   Period zero holds the timer suspended; expiry is a one-cycle pulse

`timescale 1ns/100ps
`default_nettype none

module armw_wdog #(
	parameter int TICK_CYCLES = armw_pkg::WD_TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] period,
	input  wire logic       kick,
	output logic            expire
);
	import armw_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [TW-1:0] tick;
		logic [7:0]    secs;
		logic          expire;
	} armw_wdog_t;

	armw_wdog_t state_ff;
	armw_wdog_t nxt_state;

	// Prescaler and second counter
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.expire = 1'b0;
		if (kick || period == 8'h00 || state_ff.expire) begin // R12
			nxt_state.tick = '0;
			nxt_state.secs = 8'h00;
		end else if (state_ff.tick == TICK_LAST) begin
			nxt_state.tick = '0;
			if (state_ff.secs + 8'h01 == period) begin
				nxt_state.expire = 1'b1; // R11
			end else begin
				nxt_state.secs = state_ff.secs + 8'h01;
			end
		end else begin
			nxt_state.tick = state_ff.tick + TW'(1);
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign expire = state_ff.expire;

endmodule : armw_wdog

`default_nettype wire

// ==== verilog/armw_cmd_unit.sv ====
// Purpose: Attribute read/modify/write command unit of the system controller
// Assumes: Host command and reply bytes on the same clock; strap pin synchronised here
// Notes:   Symbol attribute is two bytes wide, all others one byte
// Summary of operation
// R1: New attribute equals old AND mask, then exclusive-or with value.
// R2: After the acknowledge, always return the attribute as it was before.
// R3: Host reads an attribute with mask all ones and value zero.
// R4: Host overwrites an attribute with mask zero and the new contents as value.
// R5: Host changes bit n with mask bit n clear and value holding v.
// R6: Symbol attribute lights nine panel symbols; reply has two bytes.
// R7: Bit port bits 1 to 5 drive system control outputs at their levels.
// R8: Bit port resets with panel power high, other control outputs low.
// R9: Volume 0 to 255 drives a potentiometer, saved and restored from storage.
// R10: Brightness 0 to 255 drives a potentiometer, saved and restored from storage.
// R11: Watchdog expiry resets the system and records watchdog as reset cause.
// R12: Watchdog period is the value in seconds; zero suspends it.
// R13: Watchdog attribute is zero after power-up, so watchdog starts suspended.
// R14: Factory area stays write-protected unless unlock attribute holds ASCII w.
// R15: Two keyboard attributes hold autorepeat delay and repeat interval.
// R16: Time zone holds signed half-hour offset, mirrored in nonvolatile storage.
// R17: Mark/space attribute sets the flashing ratio of an indicator LED.
// R18: Diagnostic bit 0 shows command diagnostics, bit 1 forces 9600 baud ports.
// R19: Contrast accepts 0 to 255 and is honoured only on the low-cost variant.
// R20: Frame is opcode, mask, value; two bytes each for symbols, else one.
// R21: New value takes effect in the same transaction that returns the old.

`timescale 1ns/100ps
`default_nettype none

module armw_cmd_unit #(
	parameter int WD_TICK_CYCLES = armw_pkg::WD_TICK_CYCLES
) (
	input  wire logic                                 SYS_CLK,
	input  wire logic                                 RST_B,
	input  wire logic                                 CMD_VALID,
	input  wire logic [7:0]                           CMD_DATA,
	output logic                                      CMD_READY,
	output logic                                      RSP_VALID,
	output logic [7:0]                                RSP_DATA,
	input  wire logic                                 RSP_READY,
	input  wire logic [7:0]                           NV_VOLUME,
	input  wire logic [7:0]                           NV_BRIGHTNESS,
	input  wire logic [7:0]                           NV_TIME_ZONE,
	output logic                                      NV_WRITE,
	output logic [1:0]                                NV_WRITE_SEL,
	output logic [7:0]                                NV_WRITE_DATA,
	input  wire logic                                 LOW_COST_VARIANT,
	output logic [armw_pkg::SYMBOL_LAMPS_W-1:0]       SYMBOL_LAMPS,
	output logic                                      PANEL_POWER_OUT,
	output logic                                      MONITOR_SYNC_INVERT_A,
	output logic                                      MONITOR_SYNC_INVERT_B,
	output logic                                      BOOT_ROM_DISABLE,
	output logic                                      COMPOSITE_SYNC_ENABLE,
	output logic [7:0]                                SPEAKER_VOLUME,
	output logic [7:0]                                PANEL_BRIGHTNESS,
	output logic                                      FACTORY_WRITE_ENABLE,
	output logic [7:0]                                KEY_REPEAT_DELAY,
	output logic [7:0]                                KEY_REPEAT_INTERVAL,
	output logic [7:0]                                TIME_ZONE_OFFSET,
	output logic [7:0]                                LED_FLASH_RATIO,
	output logic                                      DIAG_CMD_DISPLAY,
	output logic                                      DIAG_KBD_9600,
	output logic [7:0]                                SCREEN_CONTRAST,
	output logic                                      SYSTEM_RESET_OUT,
	output logic                                      WDOG_RESET_CAUSE,
	input  wire logic                                 RESET_CAUSE_CLR
);
	import armw_pkg::*;

	typedef struct packed {
		armw_state_t state;
		logic [7:0]  opcode;
		logic        two_byte;
		logic        byte_cnt;
		logic [15:0] mask;
		logic [15:0] value;
		logic [15:0] old;
		logic [1:0]  rem;
		logic [7:0]  rsp_data;
		logic        restored;
		logic        variant_s1;
		logic        variant_s2;
		logic [15:0] symbol;
		logic [7:0]  bitport;
		logic [7:0]  volume;
		logic [7:0]  brightness;
		logic [7:0]  watchdog;
		logic [7:0]  unlock;
		logic [7:0]  key_delay;
		logic [7:0]  key_rate;
		logic [7:0]  time_zone;
		logic [7:0]  led_ratio;
		logic [7:0]  diag;
		logic [7:0]  contrast;
		logic [7:0]  contrast_out;
		logic        factory_we;
		logic        nv_write;
		logic [1:0]  nv_sel;
		logic [7:0]  nv_data;
		logic        wd_cause;
	} armw_regs_t;

	armw_regs_t  state_ff;
	armw_regs_t  nxt_state;
	logic        wd_kick;
	logic        wd_expire;
	logic [15:0] old_v;
	logic [15:0] new_v;

	// True for every opcode that names an attribute
	function automatic logic is_attr(input logic [7:0] opc);
		case (opc)
			OPC_SYMBOL, OPC_BITPORT, OPC_VOLUME, OPC_BRIGHTNESS,
			OPC_WATCHDOG, OPC_UNLOCK, OPC_KEY_DELAY, OPC_KEY_RATE,
			OPC_TIME_ZONE, OPC_LED_RATIO, OPC_DIAG, OPC_CONTRAST: is_attr = 1'b1;
			default: is_attr = 1'b0;
		endcase
	endfunction : is_attr

	// Watchdog timer, kicked by any command on its attribute
	armw_wdog #(
		.TICK_CYCLES (WD_TICK_CYCLES)
	) u_wdog (
		.clk    (SYS_CLK),
		.rst_b  (RST_B),
		.period (state_ff.watchdog),
		.kick   (wd_kick),
		.expire (wd_expire)
	);

	assign wd_kick = (state_ff.state == ST_EXEC) && (state_ff.opcode == OPC_WATCHDOG);

	// Old contents of the addressed attribute
	always_comb begin
		case (state_ff.opcode)
			OPC_SYMBOL:     old_v = state_ff.symbol;
			OPC_BITPORT:    old_v = {8'h00, state_ff.bitport};
			OPC_VOLUME:     old_v = {8'h00, state_ff.volume};
			OPC_BRIGHTNESS: old_v = {8'h00, state_ff.brightness};
			OPC_WATCHDOG:   old_v = {8'h00, state_ff.watchdog};
			OPC_UNLOCK:     old_v = {8'h00, state_ff.unlock};
			OPC_KEY_DELAY:  old_v = {8'h00, state_ff.key_delay};
			OPC_KEY_RATE:   old_v = {8'h00, state_ff.key_rate};
			OPC_TIME_ZONE:  old_v = {8'h00, state_ff.time_zone};
			OPC_LED_RATIO:  old_v = {8'h00, state_ff.led_ratio};
			OPC_DIAG:       old_v = {8'h00, state_ff.diag};
			OPC_CONTRAST:   old_v = {8'h00, state_ff.contrast};
			default:        old_v = 16'h0000;
		endcase
	end

	// Read/modify/write combination
	assign new_v = (old_v & state_ff.mask) ^ state_ff.value; // R1

	// Command sequencer and attribute update
	always_comb begin
		nxt_state            = state_ff;
		nxt_state.nv_write   = 1'b0;
		nxt_state.variant_s1 = LOW_COST_VARIANT;
		nxt_state.variant_s2 = state_ff.variant_s1;

		// Reload saved settings once after reset
		if (!state_ff.restored) begin
			nxt_state.volume     = NV_VOLUME; // R9
			nxt_state.brightness = NV_BRIGHTNESS; // R10
			nxt_state.time_zone  = NV_TIME_ZONE; // R16
			nxt_state.restored   = 1'b1;
		end

		case (state_ff.state)
			ST_OPCODE: begin
				if (CMD_VALID) begin
					nxt_state.opcode   = CMD_DATA;
					nxt_state.two_byte = (CMD_DATA == OPC_SYMBOL); // R20
					nxt_state.byte_cnt = (CMD_DATA == OPC_SYMBOL);
					nxt_state.mask     = 16'h0000;
					nxt_state.value    = 16'h0000;
					if (is_attr(CMD_DATA)) begin
						nxt_state.state = ST_MASK;
					end else begin
						nxt_state.rsp_data = REPLY_NAK;
						nxt_state.rem      = 2'd0;
						nxt_state.state    = ST_REPLY;
					end
				end
			end
			ST_MASK: begin
				if (CMD_VALID) begin
					nxt_state.mask = {state_ff.mask[7:0], CMD_DATA}; // R20
					if (state_ff.byte_cnt) begin
						nxt_state.byte_cnt = 1'b0;
					end else begin
						nxt_state.byte_cnt = state_ff.two_byte;
						nxt_state.state    = ST_VALUE;
					end
				end
			end
			ST_VALUE: begin
				if (CMD_VALID) begin
					nxt_state.value = {state_ff.value[7:0], CMD_DATA}; // R20
					if (state_ff.byte_cnt) begin
						nxt_state.byte_cnt = 1'b0;
					end else begin
						nxt_state.state = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				nxt_state.old      = old_v; // R2
				nxt_state.rsp_data = REPLY_ACK;
				nxt_state.rem      = state_ff.two_byte ? 2'd2 : 2'd1; // R6
				nxt_state.state    = ST_REPLY;
				// Store the new value now, at the same edge that opens the reply
				case (state_ff.opcode)
					OPC_SYMBOL:     nxt_state.symbol = new_v; // R6 R21
					OPC_BITPORT:    nxt_state.bitport = new_v[7:0]; // R7 R21
					OPC_VOLUME: begin
						nxt_state.volume   = new_v[7:0]; // R9
						nxt_state.nv_write = 1'b1;
						nxt_state.nv_sel   = NV_SEL_VOLUME;
						nxt_state.nv_data  = new_v[7:0];
					end
					OPC_BRIGHTNESS: begin
						nxt_state.brightness = new_v[7:0]; // R10
						nxt_state.nv_write   = 1'b1;
						nxt_state.nv_sel     = NV_SEL_BRIGHTNESS;
						nxt_state.nv_data    = new_v[7:0];
					end
					OPC_WATCHDOG:   nxt_state.watchdog = new_v[7:0]; // R12
					OPC_UNLOCK:     nxt_state.unlock = new_v[7:0]; // R14
					OPC_KEY_DELAY:  nxt_state.key_delay = new_v[7:0]; // R15
					OPC_KEY_RATE:   nxt_state.key_rate = new_v[7:0]; // R15
					OPC_TIME_ZONE: begin
						nxt_state.time_zone = new_v[7:0]; // R16
						nxt_state.nv_write  = 1'b1;
						nxt_state.nv_sel    = NV_SEL_TIME_ZONE;
						nxt_state.nv_data   = new_v[7:0];
					end
					OPC_LED_RATIO:  nxt_state.led_ratio = new_v[7:0]; // R17
					OPC_DIAG:       nxt_state.diag = new_v[7:0]; // R18
					OPC_CONTRAST:   nxt_state.contrast = new_v[7:0]; // R19
					default:        nxt_state.state = ST_REPLY;
				endcase
			end
			ST_REPLY: begin
				// Acknowledge first, then old contents high byte first
				if (RSP_READY) begin
					if (state_ff.rem == 2'd0) begin
						nxt_state.state = ST_OPCODE;
					end else begin
						nxt_state.rsp_data = (state_ff.rem == 2'd2) ?
							state_ff.old[15:8] : state_ff.old[7:0]; // R2
						nxt_state.rem = state_ff.rem - 2'd1;
					end
				end
			end
			default: nxt_state.state = ST_OPCODE;
		endcase

		// Derived outputs follow the stored attributes
		nxt_state.factory_we   = (nxt_state.unlock == UNLOCK_CODE); // R14
		nxt_state.contrast_out = state_ff.variant_s2 ? nxt_state.contrast : RST_BYTE; // R19

		// Reset cause: expiry wins over a clear in the same cycle
		if (wd_expire) begin
			nxt_state.wd_cause = 1'b1; // R11
		end else if (RESET_CAUSE_CLR) begin
			nxt_state.wd_cause = 1'b0;
		end
	end

	// State register, all control state defined at reset
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			state_ff            <= '0;
			state_ff.state      <= ST_OPCODE;
			state_ff.symbol     <= RST_SYMBOL;
			state_ff.bitport    <= RST_BITPORT; // R8
			state_ff.volume     <= RST_BYTE;
			state_ff.brightness <= RST_BYTE;
			state_ff.watchdog   <= RST_WATCHDOG; // R13
			state_ff.unlock     <= RST_BYTE; // R14
			state_ff.key_delay  <= RST_BYTE;
			state_ff.key_rate   <= RST_BYTE;
			state_ff.time_zone  <= RST_BYTE;
			state_ff.led_ratio  <= RST_BYTE;
			state_ff.diag       <= RST_BYTE;
			state_ff.contrast   <= RST_BYTE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Handshakes
	assign CMD_READY = (state_ff.state == ST_OPCODE) || (state_ff.state == ST_MASK) ||
		(state_ff.state == ST_VALUE);
	assign RSP_VALID = (state_ff.state == ST_REPLY);
	assign RSP_DATA  = state_ff.rsp_data;

	// Nonvolatile save strobe
	assign NV_WRITE      = state_ff.nv_write;
	assign NV_WRITE_SEL  = state_ff.nv_sel;
	assign NV_WRITE_DATA = state_ff.nv_data;

	// Controlled functions
	assign SYMBOL_LAMPS          = state_ff.symbol[SYMBOL_LAMPS_W-1:0]; // R6
	assign PANEL_POWER_OUT       = state_ff.bitport[BIT_PANEL_POWER]; // R7
	assign MONITOR_SYNC_INVERT_A = state_ff.bitport[BIT_SYNC_INVERT_A]; // R7
	assign MONITOR_SYNC_INVERT_B = state_ff.bitport[BIT_SYNC_INVERT_B]; // R7
	assign BOOT_ROM_DISABLE      = state_ff.bitport[BIT_BOOT_ROM_DIS]; // R7
	assign COMPOSITE_SYNC_ENABLE = state_ff.bitport[BIT_CSYNC_ENABLE]; // R7
	assign SPEAKER_VOLUME        = state_ff.volume;
	assign PANEL_BRIGHTNESS      = state_ff.brightness;
	assign FACTORY_WRITE_ENABLE  = state_ff.factory_we;
	assign KEY_REPEAT_DELAY      = state_ff.key_delay;
	assign KEY_REPEAT_INTERVAL   = state_ff.key_rate;
	assign TIME_ZONE_OFFSET      = state_ff.time_zone;
	assign LED_FLASH_RATIO       = state_ff.led_ratio;
	assign DIAG_CMD_DISPLAY      = state_ff.diag[DIAG_BIT_CMD_SHOW]; // R18
	assign DIAG_KBD_9600         = state_ff.diag[DIAG_BIT_KBD_9600]; // R18
	assign SCREEN_CONTRAST       = state_ff.contrast_out;
	assign SYSTEM_RESET_OUT      = wd_expire; // R11
	assign WDOG_RESET_CAUSE      = state_ff.wd_cause;

endmodule : armw_cmd_unit

`default_nettype wire

// ==== tb/armw_cmd_assertions.sv ====
// Purpose: Port-level checker for the attribute command unit
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Bound to the top module; sees its ports only
`timescale 1ns/100ps
`default_nettype none

module armw_cmd_assertions #(
	parameter int WD_TICK_CYCLES = armw_pkg::WD_TICK_CYCLES
) (
	input wire logic                        SYS_CLK,
	input wire logic                        RST_B,
	input wire logic                        CMD_VALID,
	input wire logic                        CMD_READY,
	input wire logic                        RSP_VALID,
	input wire logic                        RSP_READY,
	input wire logic [7:0]                  RSP_DATA,
	input wire logic                        NV_WRITE,
	input wire logic [1:0]                  NV_WRITE_SEL,
	input wire logic [7:0]                  NV_WRITE_DATA,
	input wire logic [7:0]                  SPEAKER_VOLUME,
	input wire logic [7:0]                  PANEL_BRIGHTNESS,
	input wire logic [7:0]                  TIME_ZONE_OFFSET,
	input wire logic [armw_pkg::SYMBOL_LAMPS_W-1:0] SYMBOL_LAMPS,
	input wire logic                        PANEL_POWER_OUT,
	input wire logic                        MONITOR_SYNC_INVERT_A,
	input wire logic                        MONITOR_SYNC_INVERT_B,
	input wire logic                        BOOT_ROM_DISABLE,
	input wire logic                        COMPOSITE_SYNC_ENABLE,
	input wire logic                        FACTORY_WRITE_ENABLE,
	input wire logic                        SYSTEM_RESET_OUT,
	input wire logic                        WDOG_RESET_CAUSE,
	input wire logic                        RESET_CAUSE_CLR
);
	import armw_pkg::*;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	// Last value byte taken, then the execute cycle
	sequence s_exec;
		CMD_VALID && CMD_READY ##1 !CMD_READY && !RSP_VALID;
	endsequence

	// Port relations over time
	property p_reset_levels;
		$rose(RST_B) |-> PANEL_POWER_OUT && !MONITOR_SYNC_INVERT_A && !MONITOR_SYNC_INVERT_B
			&& !BOOT_ROM_DISABLE && !COMPOSITE_SYNC_ENABLE && !WDOG_RESET_CAUSE;
	endproperty
	property p_no_cmd_in_reply;
		RSP_VALID |-> !CMD_READY;
	endproperty
	property p_reply_holds;
		RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA);
	endproperty
	property p_reply_opens;
		$rose(RSP_VALID) |-> RSP_DATA == REPLY_ACK || RSP_DATA == REPLY_NAK;
	endproperty
	property p_exec_reply;
		s_exec |=> RSP_VALID;
	endproperty
	property p_unlock_moves;
		!$stable(FACTORY_WRITE_ENABLE) |-> $rose(RSP_VALID);
	endproperty
	property p_lamps_move;
		!$stable(SYMBOL_LAMPS) |-> $rose(RSP_VALID);
	endproperty
	property p_expiry_cause;
		SYSTEM_RESET_OUT |=> WDOG_RESET_CAUSE && !SYSTEM_RESET_OUT;
	endproperty
	property p_cause_clear;
		WDOG_RESET_CAUSE && RESET_CAUSE_CLR && !SYSTEM_RESET_OUT |=> !WDOG_RESET_CAUSE;
	endproperty
	property p_nv_other;
		NV_WRITE && NV_WRITE_SEL != NV_SEL_VOLUME |-> $rose(RSP_VALID) && NV_WRITE_DATA ==
			(NV_WRITE_SEL == NV_SEL_BRIGHTNESS ? PANEL_BRIGHTNESS : TIME_ZONE_OFFSET);
	endproperty
	property p_nv_volume;
		NV_WRITE && NV_WRITE_SEL == NV_SEL_VOLUME |-> NV_WRITE_DATA == SPEAKER_VOLUME
			&& $rose(RSP_VALID);
	endproperty

	a_reset_levels: assert property (p_reset_levels) else $error("bit port reset levels");
	a_no_cmd_in_reply: assert property (p_no_cmd_in_reply) else $error("ready in reply");
	a_reply_holds: assert property (p_reply_holds) else $error("reply byte moved");
	a_reply_opens: assert property (p_reply_opens) else $error("reply not acked");
	a_exec_reply: assert property (p_exec_reply) else $error("reply late");
	a_unlock_moves: assert property (p_unlock_moves) else $error("unlock moved");
	a_lamps_move: assert property (p_lamps_move) else $error("lamps moved");
	a_expiry_cause: assert property (p_expiry_cause) else $error("cause not set");
	a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared");
	a_nv_volume: assert property (p_nv_volume) else $error("volume save wrong");
	a_nv_other: assert property (p_nv_other) else $error("save data wrong");

	// Main scenarios
	c_expiry: cover property ($rose(SYSTEM_RESET_OUT));
	c_exec: cover property (s_exec);
	c_nak: cover property ($rose(RSP_VALID) && RSP_DATA == REPLY_NAK);
	c_nv_save: cover property (NV_WRITE);

endmodule : armw_cmd_assertions

bind armw_cmd_unit armw_cmd_assertions #(.WD_TICK_CYCLES(WD_TICK_CYCLES)) u_chk (.*);

`default_nettype wire

// ==== tb/armw_host_model.sv ====
// Purpose: Host model sending command bytes and accepting reply bytes
// Assumes: Drives just after the falling clock edge
// Notes:   Released data shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none

module armw_host_model (
	input  wire logic       SYS_CLK,
	output logic            CMD_VALID,
	output logic [7:0]      CMD_DATA,
	input  wire logic       CMD_READY,
	output logic            RSP_READY
);
	bit slow = 1'b0;

	// Idle levels at time zero
	initial begin
		CMD_VALID = 1'b0;
		CMD_DATA  = 8'h00;
		RSP_READY = 1'b1;
	end

	// Reply acceptance, random stalls when slow
	always @(negedge SYS_CLK) begin
		RSP_READY <= slow ? 1'($urandom % 2) : 1'b1;
	end

	// One byte held until the edge that takes it
	task automatic send_byte(input logic [7:0] b);
		CMD_VALID = 1'b1;
		CMD_DATA  = b;
		while (CMD_READY !== 1'b1) @(negedge SYS_CLK);
		@(negedge SYS_CLK);
	endtask : send_byte

	// Release after a frame
	task automatic idle();
		CMD_VALID = 1'b0;
		CMD_DATA  = ~CMD_DATA;
	endtask : idle

endmodule : armw_host_model

`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the attribute command unit
// Assumes: Short watchdog second of ten cycles
// Notes:   Reply bytes are checked against a queue of expected bytes
`timescale 1ns/100ps
`default_nettype none

module tb;
	import armw_pkg::*;
	localparam int TICK = 10;
	localparam logic [7:0] OPS [12] = '{OPC_SYMBOL, OPC_BITPORT, OPC_VOLUME, OPC_BRIGHTNESS,
		OPC_WATCHDOG, OPC_UNLOCK, OPC_KEY_DELAY, OPC_KEY_RATE, OPC_TIME_ZONE, OPC_LED_RATIO,
		OPC_DIAG, OPC_CONTRAST};
	logic        SYS_CLK, RST_B, CMD_VALID, CMD_READY, RSP_VALID, RSP_READY, NV_WRITE;
	logic        LOW_COST_VARIANT, PANEL_POWER_OUT, MONITOR_SYNC_INVERT_A, MONITOR_SYNC_INVERT_B;
	logic        BOOT_ROM_DISABLE, COMPOSITE_SYNC_ENABLE, FACTORY_WRITE_ENABLE, DIAG_CMD_DISPLAY;
	logic        DIAG_KBD_9600, SYSTEM_RESET_OUT, WDOG_RESET_CAUSE, RESET_CAUSE_CLR;
	logic [1:0]  NV_WRITE_SEL;
	logic [8:0]  SYMBOL_LAMPS;
	logic [7:0]  CMD_DATA, RSP_DATA, NV_VOLUME, NV_BRIGHTNESS, NV_TIME_ZONE, NV_WRITE_DATA;
	logic [7:0]  SPEAKER_VOLUME, PANEL_BRIGHTNESS, KEY_REPEAT_DELAY, KEY_REPEAT_INTERVAL;
	logic [7:0]  TIME_ZONE_OFFSET, LED_FLASH_RATIO, SCREEN_CONTRAST;
	logic [15:0] shadow [256];
	logic [7:0]  exp_q [$];
	int          num_errors, check_count, n;

	armw_cmd_unit #(.WD_TICK_CYCLES(TICK)) dut (.*);
	armw_host_model host (.SYS_CLK(SYS_CLK), .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA),
		.CMD_READY(CMD_READY), .RSP_READY(RSP_READY));

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	// Wait until every expected reply byte was taken
	task automatic wait_done();
		n = 0;
		while (exp_q.size() > 0 && n < 300) begin
			@(negedge SYS_CLK);
			n++;
		end
		chk(16'(exp_q.size()), 16'h0000);
		repeat (2) @(negedge SYS_CLK);
	endtask : wait_done

	// Controlled output against the new attribute value
	task automatic port_chk(input logic [7:0] op, input logic [15:0] nv);
		case (op)
			OPC_SYMBOL: chk({7'h00, SYMBOL_LAMPS}, nv & 16'h01FF);
			OPC_BITPORT: chk({10'h000, COMPOSITE_SYNC_ENABLE, BOOT_ROM_DISABLE,
				MONITOR_SYNC_INVERT_B, MONITOR_SYNC_INVERT_A, PANEL_POWER_OUT, 1'b0},
				nv & 16'h003E);
			OPC_VOLUME: chk({8'h00, SPEAKER_VOLUME}, nv);
			OPC_BRIGHTNESS: chk({8'h00, PANEL_BRIGHTNESS}, nv);
			OPC_UNLOCK: chk({15'h0000, FACTORY_WRITE_ENABLE}, 16'(nv == 16'h0077));
			OPC_KEY_DELAY: chk({8'h00, KEY_REPEAT_DELAY}, nv);
			OPC_KEY_RATE: chk({8'h00, KEY_REPEAT_INTERVAL}, nv);
			OPC_TIME_ZONE: chk({8'h00, TIME_ZONE_OFFSET}, nv);
			OPC_LED_RATIO: chk({8'h00, LED_FLASH_RATIO}, nv);
			OPC_DIAG: chk({14'h0000, DIAG_KBD_9600, DIAG_CMD_DISPLAY}, nv & 16'h0003);
			OPC_CONTRAST: chk({8'h00, SCREEN_CONTRAST}, LOW_COST_VARIANT ? nv : 16'h0000);
			default: ;
		endcase
	endtask : port_chk

	// One read/modify/write command with its expected reply
	task automatic rmw(input logic [7:0] op, input logic [15:0] m, input logic [15:0] v);
		logic [15:0] nv;
		logic [7:0]  fr [$];
		nv = (shadow[op] & m) ^ v;
		fr = {op, m[7:0], v[7:0]};
		exp_q.push_back(REPLY_ACK);
		if (op == OPC_SYMBOL) begin
			fr = {op, m[15:8], m[7:0], v[15:8], v[7:0]};
			exp_q.push_back(shadow[op][15:8]);
		end
		exp_q.push_back(shadow[op][7:0]);
		foreach (fr[i]) host.send_byte(fr[i]);
		host.idle();
		shadow[op] = nv;
		wait_done();
		port_chk(op, nv);
	endtask : rmw

	// Reply monitor, sampled while the byte stands before its taking edge
	always begin
		@(negedge SYS_CLK);
		#1;
		if (RSP_VALID === 1'b1 && RSP_READY === 1'b1) begin
			chk({8'h00, RSP_DATA}, (exp_q.size() > 0) ?
				{8'h00, exp_q.pop_front()} : 16'h0100);
		end
	end

	// Clock
	initial begin
		SYS_CLK = 1'b0;
		forever #50 SYS_CLK = ~SYS_CLK;
	end

	// Watchdog on the whole run
	initial begin
		repeat (30000) @(posedge SYS_CLK);
		num_errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		logic [15:0] m;
		void'($urandom(32'h6ED7));
		RST_B            = 1'b0;
		RESET_CAUSE_CLR  = 1'b0;
		LOW_COST_VARIANT = 1'b1;
		NV_VOLUME        = 8'($urandom);
		NV_BRIGHTNESS    = 8'($urandom);
		NV_TIME_ZONE     = 8'($urandom);
		foreach (shadow[i]) shadow[i] = 16'h0000;
		shadow[OPC_BITPORT]    = 16'h0002;
		shadow[OPC_VOLUME]     = {8'h00, NV_VOLUME};
		shadow[OPC_BRIGHTNESS] = {8'h00, NV_BRIGHTNESS};
		shadow[OPC_TIME_ZONE]  = {8'h00, NV_TIME_ZONE};
		repeat (8) @(negedge SYS_CLK);
		RST_B = 1'b1;
		repeat (4) @(negedge SYS_CLK);
		foreach (OPS[i]) port_chk(OPS[i], shadow[OPS[i]]);
		rmw(OPC_WATCHDOG, 16'h00FF, 16'h0000);
		$display("test reset done");
		host.slow = 1'b1;
		foreach (OPS[i]) begin
			m = (OPS[i] == OPC_SYMBOL) ? 16'hFFFF : 16'h00FF;
			rmw(OPS[i], 16'h0000, 16'($urandom) & m);
			rmw(OPS[i], 16'($urandom) & m, 16'($urandom) & m);
			rmw(OPS[i], m, 16'h0000);
		end
		$display("test rmw done");
		for (int b = 1; b <= 5; b++) begin
			rmw(OPC_BITPORT, ~(16'h0001 << b) & 16'h00FF, 16'($urandom % 2) << b);
		end
		rmw(OPC_UNLOCK, 16'h0000, 16'h0077);
		rmw(OPC_UNLOCK, 16'h0000, 16'h0076);
		LOW_COST_VARIANT = 1'b0;
		repeat (3) @(negedge SYS_CLK);
		rmw(OPC_CONTRAST, 16'h0000, 16'h00A5);
		exp_q.push_back(REPLY_NAK);
		host.send_byte(8'h22);
		host.idle();
		wait_done();
		$display("test bits done");
		host.slow = 1'b0;
		rmw(OPC_WATCHDOG, 16'h0000, 16'h0002);
		n = 0;
		while (SYSTEM_RESET_OUT !== 1'b1 && n < 60) begin
			@(negedge SYS_CLK);
			n++;
		end
		chk(16'(n >= 10 && n <= 24), 16'h0001);
		@(negedge SYS_CLK);
		chk({15'h0000, WDOG_RESET_CAUSE}, 16'h0001);
		RESET_CAUSE_CLR = 1'b1;
		@(negedge SYS_CLK);
		RESET_CAUSE_CLR = 1'b0;
		@(negedge SYS_CLK);
		chk({15'h0000, WDOG_RESET_CAUSE}, 16'h0000);
		rmw(OPC_WATCHDOG, 16'h0000, 16'h0000);
		n = 0;
		repeat (80) begin
			@(negedge SYS_CLK);
			n += int'(SYSTEM_RESET_OUT === 1'b1);
		end
		chk(16'(n), 16'h0000);
		$display("test watchdog done");
		give_verdict();
	end

endmodule : tb

`default_nettype wire
